/* design/smsr_device.sv */
`timescale 1ns/10ps
`default_nettype none

module smsr_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // Full and empty come from the occupancy count, so neither can lie.
   assign in_ready  = (count_reg != FULL_COUNT);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage is written only on an accepted push.
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers wrap at the last slot, so any depth works.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_SLOT) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_SLOT) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule

module smsr_device
   import smsr_pkg::*;
#(
   parameter int FIFO_DEPTH = SMSR_FIFO_DEPTH
)
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       cs_n_pin,
   input  wire logic       sck_pin,
   input  wire logic [3:0] io_in,
   output logic [3:0]      io_out,
   output logic [3:0]      io_oe,
   input  wire logic       power_restore_pin,
   output logic [7:0]      status_protection_register,
   output logic [1:0]      protect_region,
   output logic            quad_command_mode_flag,
   output logic            spi_mode3,
   output logic            standby,
   output logic            xfer_overflow,
   output logic            xfer_valid,
   input  wire logic       xfer_ready,
   output smsr_xfer_t      xfer_data
);

   // Byte completes after eight single-line or two quad-line rising edges.
   function automatic logic smsr_byte_last(input logic [2:0] cnt, input logic quad);
      smsr_byte_last = quad ? cnt[2] : (cnt == 3'h7);
   endfunction

   // Advance a bit counter by one line or four lines per edge.
   function automatic logic [2:0] smsr_step(input logic [2:0] cnt, input logic quad);
      smsr_step = quad ? (cnt + 3'h4) : (cnt + 3'h1);
   endfunction

   logic [SMSR_SYNC_STAGES-1:0] cs_sync_reg;
   logic [SMSR_SYNC_STAGES-1:0] sck_sync_reg;
   logic [SMSR_SYNC_STAGES-1:0] pwr_sync_reg;
   logic [3:0]                  io_meta_reg;
   logic [3:0]                  io_sync_reg;
   logic                        sck_prev_reg;
   logic                        pwr_prev_reg;
   logic                        cs_eff_reg;
   smsr_phase_t                 phase_reg;
   logic [7:0]                  shift_reg;
   logic [2:0]                  bit_cnt_reg;
   logic [2:0]                  rd_cnt_reg;
   logic [7:0]                  cmd_reg;
   logic                        body_first_reg;
   logic [7:0]                  status_reg;
   logic                        mode3_reg;
   logic [3:0]                  io_out_reg;
   logic [3:0]                  io_oe_reg;
   logic [1:0]                  protect_reg;
   logic                        standby_reg;
   logic                        overflow_reg;

   logic       cs_s;
   logic       sck_s;
   logic       quad;
   logic       hold_act;
   logic       frame_start;
   logic       frame_end;
   logic       rise_ev;
   logic       fall_ev;
   logic       byte_done;
   logic [7:0] shift_next;
   logic       status_cmd;
   logic       push_valid;
   logic       push_ready;
   logic       power_restore;
   logic       status_write_cmd_allowed;
   smsr_xfer_t push_data;

   // Two flops on every pin; only the second flop is read by logic.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_sync_reg  <= '1;
         sck_sync_reg <= '0;
         pwr_sync_reg <= '0;
         io_meta_reg  <= 4'hF;
         io_sync_reg  <= 4'hF;
      end
      else
      begin
         cs_sync_reg  <= {cs_sync_reg[0], cs_n_pin};
         sck_sync_reg <= {sck_sync_reg[0], sck_pin};
         pwr_sync_reg <= {pwr_sync_reg[0], power_restore_pin};
         io_meta_reg  <= io_in;
         io_sync_reg  <= io_meta_reg;
      end
   end

   assign cs_s  = cs_sync_reg[SMSR_SYNC_STAGES-1];
   assign sck_s = sck_sync_reg[SMSR_SYNC_STAGES-1];
   assign quad  = status_reg[SMSR_BIT_QUAD_FLAG];

   // Suspend only exists in single mode; in quad mode line 3 carries data.
   assign hold_act    = ~quad & ~io_sync_reg[SMSR_IO_SUSPEND];
   assign frame_start = ~hold_act & cs_eff_reg & ~cs_s;
   assign frame_end   = ~hold_act & ~cs_eff_reg & cs_s;

   // Edges count only inside a frame and outside suspend.
   assign rise_ev = ~hold_act & ~cs_eff_reg & sck_s & ~sck_prev_reg;
   assign fall_ev = ~hold_act & ~cs_eff_reg & ~sck_s & sck_prev_reg;

   // Quad mode takes four lines per edge, single mode only the input line.
   assign shift_next = quad ? {shift_reg[3:0], io_sync_reg}
                            : {shift_reg[6:0], io_sync_reg[SMSR_IO_SERIAL_IN]};
   assign byte_done  = rise_ev & smsr_byte_last(bit_cnt_reg, quad);

   assign status_cmd = (cmd_reg == SMSR_CMD_STATUS_READ) ||
                       (cmd_reg == SMSR_CMD_STATUS_WRITE);

   // A latch-cleared device protects the status register outright.
   // Write-protect is a data line in quad mode, so there a set disable bit
   // alone locks the protection fields.
   assign status_write_cmd_allowed = status_reg[SMSR_BIT_WRITE_ENABLE_LATCH] &
                         (quad ? ~status_reg[SMSR_BIT_STATUS_WRITE_DISABLE]
                               : io_sync_reg[SMSR_IO_WRITE_PROT]);

   assign power_restore = pwr_sync_reg[SMSR_SYNC_STAGES-1] & ~pwr_prev_reg;

   // Bytes after any non-status command leave through the buffer.
   assign push_valid     = byte_done && (phase_reg == SMSR_BODY) && !status_cmd;
   assign push_data.cmd  = cmd_reg;
   assign push_data.data = shift_next;

   // Clock history and the suspend-frozen view of chip select.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_prev_reg <= 1'b0;
         pwr_prev_reg <= 1'b0;
         cs_eff_reg   <= 1'b1;
      end
      else
      begin
         sck_prev_reg <= sck_s;
         pwr_prev_reg <= pwr_sync_reg[SMSR_SYNC_STAGES-1];
         if (!hold_act)
         begin
            cs_eff_reg <= cs_s;
         end
      end
   end

   // Clock polarity is caught once, at the select falling edge.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode3_reg <= 1'b0;
      end
      else if (frame_start)
      begin
         mode3_reg <= sck_s;
      end
   end

   // Frame sequencing; nothing moves between edges, so a stopped clock is harmless.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_reg      <= SMSR_IDLE;
         shift_reg      <= 8'h00;
         bit_cnt_reg    <= 3'h0;
         cmd_reg        <= 8'h00;
         body_first_reg <= 1'b0;
      end
      else
      begin
         case (phase_reg)
            SMSR_IDLE:
            begin
               if (frame_start)
               begin
                  phase_reg   <= SMSR_CMD;
                  bit_cnt_reg <= 3'h0;
               end
            end
            SMSR_CMD, SMSR_BODY:
            begin
               if (frame_end)
               begin
                  phase_reg <= SMSR_IDLE;
               end
               else if (rise_ev)
               begin
                  shift_reg   <= shift_next;
                  bit_cnt_reg <= smsr_step(bit_cnt_reg, quad);
                  if (byte_done && phase_reg == SMSR_CMD)
                  begin
                     cmd_reg        <= shift_next;
                     phase_reg      <= SMSR_BODY;
                     body_first_reg <= 1'b1;
                  end
                  else if (byte_done)
                  begin
                     body_first_reg <= 1'b0;
                  end
               end
            end
            default:
            begin
               phase_reg <= SMSR_IDLE;
            end
         endcase
      end
   end

   // Status register: power-loss recovery first, then command effects.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_reg <= SMSR_STATUS_RESET;
      end
      else if (power_restore)
      begin
         // Only the volatile bits fall back; protection survives a power loss.
         status_reg[SMSR_BIT_WRITE_ENABLE_LATCH] <= 1'b0;
         status_reg[SMSR_BIT_QUAD_FLAG]          <= 1'b0;
      end
      else if (byte_done && phase_reg == SMSR_CMD)
      begin
         case (shift_next)
            SMSR_CMD_WRITE_LATCH_SET:
            begin
               status_reg[SMSR_BIT_WRITE_ENABLE_LATCH] <= 1'b1;
            end
            SMSR_CMD_WRITE_LATCH_CLR:
            begin
               status_reg[SMSR_BIT_WRITE_ENABLE_LATCH] <= 1'b0;
            end
            SMSR_CMD_QUAD_MODE_ENTER:
            begin
               status_reg[SMSR_BIT_QUAD_FLAG] <= 1'b1;
            end
            SMSR_CMD_QUAD_MODE_EXIT:
            begin
               status_reg[SMSR_BIT_QUAD_FLAG] <= 1'b0;
            end
            default:
            begin
               status_reg <= status_reg;
            end
         endcase
      end
      else if (byte_done && body_first_reg && phase_reg == SMSR_BODY &&
               cmd_reg == SMSR_CMD_STATUS_WRITE && status_write_cmd_allowed)
      begin
         // Quad flag and latch keep their state; the other six bits are stored as written.
         status_reg <= {shift_next[SMSR_BIT_STATUS_WRITE_DISABLE],
                        status_reg[SMSR_BIT_QUAD_FLAG],
                        shift_next[SMSR_BIT_RSV_HI:SMSR_BIT_BLOCK_PROTECT_LOW],
                        status_reg[SMSR_BIT_WRITE_ENABLE_LATCH],
                        shift_next[SMSR_BIT_RSV_LO]};
      end
   end

   // Read data goes out on falling edges only, after the command byte.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         io_out_reg <= 4'h0;
         io_oe_reg  <= 4'h0;
         rd_cnt_reg <= 3'h0;
      end
      else if (frame_start || frame_end || hold_act || phase_reg != SMSR_BODY)
      begin
         io_oe_reg  <= 4'h0;
         rd_cnt_reg <= 3'h0;
      end
      else if (fall_ev && cmd_reg == SMSR_CMD_STATUS_READ)
      begin
         rd_cnt_reg <= smsr_step(rd_cnt_reg, quad);
         if (quad)
         begin
            io_out_reg <= rd_cnt_reg[2] ? status_reg[3:0] : status_reg[7:4];
            io_oe_reg  <= 4'hF;
         end
         else
         begin
            io_out_reg[SMSR_IO_SERIAL_OUT] <= status_reg[3'h7 - rd_cnt_reg];
            io_oe_reg                      <= 4'h2;
         end
      end
   end

   // Effective protection: a cleared latch protects everything.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         protect_reg <= SMSR_PROT_ALL;
         standby_reg <= 1'b1;
      end
      else
      begin
         protect_reg <= status_reg[SMSR_BIT_WRITE_ENABLE_LATCH] ?
                        status_reg[SMSR_BIT_BLOCK_PROTECT_HIGH:SMSR_BIT_BLOCK_PROTECT_LOW] :
                        SMSR_PROT_ALL;
         standby_reg <= cs_eff_reg;
      end
   end

   // The link cannot be stalled, so a byte meeting a full buffer is dropped and flagged.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         overflow_reg <= 1'b0;
      end
      else if (push_valid && !push_ready)
      begin
         overflow_reg <= 1'b1;
      end
      else if (frame_start)
      begin
         overflow_reg <= 1'b0;
      end
   end

   smsr_fifo #(
      .WIDTH ($bits(smsr_xfer_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (xfer_valid),
      .out_ready (xfer_ready),
      .out_data  (xfer_data)
   );

   assign io_out                     = io_out_reg;
   assign io_oe                      = io_oe_reg;
   assign status_protection_register = status_reg;
   assign protect_region             = protect_reg;
   assign quad_command_mode_flag     = status_reg[SMSR_BIT_QUAD_FLAG];
   assign spi_mode3                  = mode3_reg;
   assign standby                    = standby_reg;
   assign xfer_overflow              = overflow_reg;

endmodule

`default_nettype wire

/* inc/smsr_pkg.sv */
`default_nettype none

package smsr_pkg;

   // Status register field positions.
   localparam int SMSR_BIT_STATUS_WRITE_DISABLE = 7;
   localparam int SMSR_BIT_QUAD_FLAG            = 6;
   localparam int SMSR_BIT_RSV_HI               = 5;
   localparam int SMSR_BIT_RSV_MID              = 4;
   localparam int SMSR_BIT_BLOCK_PROTECT_HIGH   = 3;
   localparam int SMSR_BIT_BLOCK_PROTECT_LOW    = 2;
   localparam int SMSR_BIT_WRITE_ENABLE_LATCH   = 1;
   localparam int SMSR_BIT_RSV_LO               = 0;

   // Every bit leaves the factory cleared.
   localparam logic [7:0] SMSR_STATUS_RESET = 8'h00;

   // Command codes seen on the link.
   localparam logic [7:0] SMSR_CMD_STATUS_READ      = 8'h05;
   localparam logic [7:0] SMSR_CMD_WRITE_LATCH_SET  = 8'h06;
   localparam logic [7:0] SMSR_CMD_WRITE_LATCH_CLR  = 8'h04;
   localparam logic [7:0] SMSR_CMD_STATUS_WRITE     = 8'h01;
   localparam logic [7:0] SMSR_CMD_QUAD_MODE_ENTER  = 8'h38;
   localparam logic [7:0] SMSR_CMD_QUAD_MODE_EXIT   = 8'hFF;

   // Protected region encoding on the protection output.
   localparam logic [1:0] SMSR_PROT_NONE  = 2'h0;
   localparam logic [1:0] SMSR_PROT_QUART = 2'h1;
   localparam logic [1:0] SMSR_PROT_HALF  = 2'h2;
   localparam logic [1:0] SMSR_PROT_ALL   = 2'h3;

   // Link clock limit and the oversampling clock.
   localparam int SMSR_SCK_MAX_KHZ    = 104000;
   localparam int SMSR_CLK_KHZ        = 40000;
   localparam int SMSR_SYNC_STAGES    = 2;
   // Least link clock period that the oversampler follows: four clk cycles per period.
   localparam int SMSR_SCK_MIN_CLKS   = 4;
   localparam int SMSR_FIFO_DEPTH     = 8;

   // Link pin positions on the four data lines.
   localparam int SMSR_IO_SERIAL_IN   = 0;
   localparam int SMSR_IO_SERIAL_OUT  = 1;
   localparam int SMSR_IO_WRITE_PROT  = 2;
   localparam int SMSR_IO_SUSPEND     = 3;

   typedef enum logic [1:0]
   {
      SMSR_IDLE = 2'b00,
      SMSR_CMD  = 2'b01,
      SMSR_BODY = 2'b10
   } smsr_phase_t;

   // One byte that followed a command, tagged with the command.
   typedef struct packed
   {
      logic [7:0] cmd;
      logic [7:0] data;
   } smsr_xfer_t;

endpackage

`default_nettype wire

/* testbench/smsr_device_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

module smsr_asserts
   import smsr_pkg::*;
#(
   parameter int FIFO_DEPTH = SMSR_FIFO_DEPTH
)
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       cs_n_pin,
   input wire logic       sck_pin,
   input wire logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe,
   input wire logic       power_restore_pin,
   input wire logic [7:0] status_protection_register,
   input wire logic [1:0] protect_region,
   input wire logic       quad_command_mode_flag,
   input wire logic       spi_mode3,
   input wire logic       standby,
   input wire logic       xfer_overflow,
   input wire logic       xfer_valid,
   input wire logic       xfer_ready,
   input wire smsr_xfer_t xfer_data
);
   logic       sck_q;
   logic [3:0] since_fall;
   logic [3:0] since_sel;

   // Ages of the last link clock fall and of the last selected cycle, saturating at 15.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_q      <= 1'b0;
         since_fall <= 4'hF;
         since_sel  <= 4'hF;
      end
      else
      begin
         sck_q      <= sck_pin;
         since_fall <= (sck_q && !sck_pin) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
         since_sel  <= !cs_n_pin ? 4'h0 : since_sel + {3'h0, since_sel != 4'hF};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // The synchronisers add latency, so the idle and suspend checks wait five cycles.
   sequence s_deselected;
      cs_n_pin [*5];
   endsequence
   sequence s_suspended;
      (!io_in[3] && !quad_command_mode_flag) [*5];
   endsequence

   a_idle_no_drive: assert property (s_deselected |-> io_oe == 4'h0)
      else $error("output driven while deselected");
   a_idle_standby: assert property (s_deselected |-> standby)
      else $error("standby missing while deselected");
   a_single_oe_line: assert property (!quad_command_mode_flag && io_oe != 4'h0 |-> io_oe == 4'h2)
      else $error("single mode drives a line other than the output");
   a_quad_oe_all: assert property (quad_command_mode_flag && io_oe != 4'h0 |-> io_oe == 4'hF)
      else $error("quad read does not drive all four lines");
   a_suspend_float: assert property (s_suspended |-> io_oe == 4'h0)
      else $error("output driven while suspended");
   a_out_after_fall: assert property ($changed(io_out) && io_oe != 4'h0 |-> since_fall <= 4'd6)
      else $error("output changed away from a clock fall");
   a_latch_protect_all: assert property (!status_protection_register[1] [*2] |-> protect_region == 2'h3)
      else $error("region not all while latch clear");
   a_region_follow: assert property (status_protection_register[1] [*2]
      |-> protect_region == $past(status_protection_register[3:2]))
      else $error("region does not follow block bits");
   a_quad_set_frame: assert property ($rose(quad_command_mode_flag) |-> since_sel <= 4'd6)
      else $error("quad flag set outside a frame");
   a_bits_keep_idle: assert property ($changed({status_protection_register[7],
      status_protection_register[5:2], status_protection_register[0]}) |-> since_sel <= 4'd6)
      else $error("status bits changed outside a frame");
endmodule

bind smsr_device smsr_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_asserts (
   .clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .io_in(io_in),
   .io_out(io_out), .io_oe(io_oe), .power_restore_pin(power_restore_pin),
   .status_protection_register(status_protection_register), .protect_region(protect_region),
   .quad_command_mode_flag(quad_command_mode_flag), .spi_mode3(spi_mode3), .standby(standby),
   .xfer_overflow(xfer_overflow), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
   .xfer_data(xfer_data));

`default_nettype wire

/* testbench/smsr_host.sv */
`timescale 1ns/10ps
`default_nettype none

module smsr_host
(
   input  wire logic       clk,
   output var logic        cs_n,
   output var logic        sck,
   output var logic [3:0]  io_drv,
   output var logic [3:0]  io_en,
   input  wire logic [3:0] io_rd
);
   logic mode3;
   logic quad;
   logic wprot;
   logic suspend_n;

   // The host idles deselected with write-protect and suspend pins high.
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      io_drv = 4'hD;
      io_en = 4'hD;
      mode3 = 1'b0;
      quad = 1'b0;
      wprot = 1'b1;
      suspend_n = 1'b1;
   end

   // Half a link period is four system clocks, a 200 ns period far below the top rate.
   task automatic hw();
      repeat (4) @(posedge clk);
      #1;
   endtask

   // Data is set up a half period before the rise and read back just before the next fall.
   task automatic tick(input logic [3:0] d, output logic [3:0] q);
      io_drv = d;
      if (!mode3)
      begin
         hw();
         sck = 1'b1;
         hw();
         q = io_rd;
         sck = 1'b0;
      end
      else
      begin
         sck = 1'b0;
         hw();
         sck = 1'b1;
         hw();
         q = io_rd;
      end
   endtask

   // The clock rests at the level of the chosen mode before select falls.
   task automatic open_frame(input logic m3);
      mode3 = m3;
      sck = m3;
      hw();
      cs_n = 1'b0;
      hw();
   endtask

   task automatic close_frame();
      hw();
      cs_n = 1'b1;
      hw();
      hw();
   endtask

   // Suspend only moves inside a frame.
   task automatic set_suspend(input logic v);
      suspend_n = v;
      io_drv[3] = v;
      hw();
   endtask

   // One byte, MSB first: eight single-line bits or two nibbles; quad reads release all four lines.
   task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
      logic [3:0] q;
      io_en = quad ? (rd ? 4'h0 : 4'hF) : 4'hD;
      if (quad)
      begin
         tick(tx[7:4], q);
         rx[7:4] = q;
         tick(tx[3:0], q);
         rx[3:0] = q;
      end
      else
      begin
         for (int i = 7; i >= 0; i--)
         begin
            tick({suspend_n, wprot, 1'b0, tx[i]}, q);
            rx[i] = q[1];
         end
      end
   endtask
endmodule

`default_nettype wire

/* testbench/tb_smsr_device.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_smsr_device
   import smsr_pkg::*;
;
   logic       clk;
   logic       rst_n;
   logic       pwr;
   logic       xrdy;
   logic       tog;
   logic       m3;
   logic       cs_n;
   logic       sck;
   logic [3:0] h_drv;
   logic [3:0] h_en;
   logic [3:0] d_out;
   logic [3:0] d_oe;
   logic [3:0] io_line;
   logic [7:0] status;
   logic [7:0] rx;
   logic [1:0] region;
   logic       qflag;
   logic       mode3;
   logic       stby;
   logic       ovf;
   logic       xv;
   smsr_xfer_t xd;
   int         n_mismatch;
   int         samples_checked;

   // Released lines toggle each cycle so a floating pin never reads back by luck.
   assign io_line = (d_oe & d_out) | (~d_oe & h_en & h_drv) | (~d_oe & ~h_en & {4{tog}});

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) tog <= ~tog;

   smsr_device #(.FIFO_DEPTH(8)) u_dut (
      .clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sck_pin(sck), .io_in(io_line),
      .io_out(d_out), .io_oe(d_oe), .power_restore_pin(pwr),
      .status_protection_register(status), .protect_region(region),
      .quad_command_mode_flag(qflag), .spi_mode3(mode3), .standby(stby),
      .xfer_overflow(ovf), .xfer_valid(xv), .xfer_ready(xrdy), .xfer_data(xd));

   smsr_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .io_drv(h_drv), .io_en(h_en),
      .io_rd(io_line));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic op(input logic [7:0] c);
      u_host.open_frame(m3);
      u_host.xfer(c, 1'b0, rx);
      u_host.close_frame();
   endtask

   task automatic wr_status(input logic [7:0] d);
      u_host.open_frame(m3);
      u_host.xfer(SMSR_CMD_STATUS_WRITE, 1'b0, rx);
      u_host.xfer(d, 1'b0, rx);
      u_host.close_frame();
   endtask

   // A status read also confirms which lines the device drives while answering.
   task automatic rd_status(input logic [7:0] exp);
      u_host.open_frame(m3);
      u_host.xfer(SMSR_CMD_STATUS_READ, 1'b0, rx);
      u_host.xfer(8'h00, 1'b1, rx);
      check(16'(d_oe), u_host.quad ? 16'h000F : 16'h0002, "read enables");
      check(16'(rx), 16'(exp), "status read");
      u_host.close_frame();
   endtask

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // The full run needs roughly 3000 cycles; the limit leaves ample slack.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end

   initial
   begin
      rst_n = 1'b0;
      pwr = 1'b0;
      xrdy = 1'b0;
      tog = 1'b0;
      m3 = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(16'(status), 16'h0000, "factory status");
      check(16'(region), 16'h0003, "region after reset");
      check({14'h0, stby, qflag}, 16'h0002, "idle standby, quad flag");
      rd_status(8'h00);
      wr_status(8'hBD);
      check(16'(status), 16'h0000, "write with latch clear");
      op(SMSR_CMD_WRITE_LATCH_SET);
      rd_status(8'h02);
      wr_status(8'hFF);
      check(16'(status), 16'h00BF, "full write");
      for (int bp = 0; bp < 4; bp++)
      begin
         wr_status(8'h80 | 8'(bp << 2));
         check(16'(status), 16'(8'h82 | 8'(bp << 2)), "block bits");
         check(16'(region), 16'(bp), "region code");
      end
      u_host.wprot = 1'b0;
      wr_status(8'h00);
      check(16'(status), 16'h008E, "write under protect pin");
      u_host.wprot = 1'b1;
      m3 = 1'b1;
      rd_status(8'h8E);
      check(16'(mode3), 16'h0001, "mode 3 capture");
      m3 = 1'b0;
      // Suspend mid-read floats the output; a latch clear sent while suspended
      // must not become the frame's command, so the read after it still answers.
      u_host.open_frame(1'b0);
      u_host.xfer(SMSR_CMD_STATUS_READ, 1'b0, rx);
      u_host.xfer(8'h00, 1'b1, rx);
      u_host.set_suspend(1'b0);
      check(16'(d_oe), 16'h0000, "suspended output");
      u_host.set_suspend(1'b1);
      u_host.close_frame();
      u_host.open_frame(1'b0);
      u_host.set_suspend(1'b0);
      u_host.xfer(SMSR_CMD_WRITE_LATCH_CLR, 1'b0, rx);
      u_host.set_suspend(1'b1);
      u_host.xfer(SMSR_CMD_STATUS_READ, 1'b0, rx);
      u_host.xfer(8'h00, 1'b1, rx);
      check(16'(rx), 16'h008E, "read after suspend");
      u_host.close_frame();
      check(16'(status), 16'h008E, "suspended frame");
      check(16'(mode3), 16'h0000, "mode 0 capture");
      op(SMSR_CMD_QUAD_MODE_ENTER);
      check(16'(qflag), 16'h0001, "quad entered");
      u_host.quad = 1'b1;
      rd_status(8'hCE);
      wr_status(8'h00);
      check(16'(status), 16'h00CE, "quad write locked");
      op(SMSR_CMD_QUAD_MODE_EXIT);
      u_host.quad = 1'b0;
      check(16'(status), 16'h008E, "quad left");
      pwr = 1'b1;
      repeat (4) @(posedge clk);
      #1 pwr = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check(16'(status), 16'h008C, "after power loss");
      op(SMSR_CMD_WRITE_LATCH_SET);
      op(SMSR_CMD_WRITE_LATCH_CLR);
      check(16'(status), 16'h008C, "latch cleared");
      check(16'(region), 16'h0003, "region latch clear");
      // Nine body bytes against a stalled reader: eight stay, one is dropped.
      u_host.open_frame(1'b0);
      u_host.xfer(8'h02, 1'b0, rx);
      for (int i = 0; i < 9; i++)
         u_host.xfer(8'hA0 + 8'(i), 1'b0, rx);
      u_host.close_frame();
      check({14'h0, xv, ovf}, 16'h0003, "buffer full");
      for (int i = 0; i < 8; i++)
      begin
         check(xd, {8'h02, 8'hA0 + 8'(i)}, "buffer word");
         xrdy = 1'b1;
         @(posedge clk);
         #1 xrdy = 1'b0;
         @(posedge clk);
         #1;
      end
      check(16'(xv), 16'h0000, "buffer empty");
      final_report();
   end
endmodule

`default_nettype wire
